// [rtl/rtc_top.sv]
// Operation
// - bit 7 turns fixed reference on/off
// - bit 6 read-only ready flag
// - standard variant: ready always reads one
// - ready sets only after settling
// - bit 5 enables temperature sensor
// - bit 4 selects sensor range
// - bits 3:2 comparator buffer gain
// - bits 1:0 converter buffer gain
// - sensor routed to reserved converter channel
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rtc_top #(
   parameter bit STANDARD_VARIANT = 1'b0,
   parameter int SETTLE_CYCLES    = rtc_pkg::SETTLE_CYCLES,
   parameter int TEMP_ACQ_CYCLES  = rtc_pkg::TEMP_ACQ_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [3:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   temp_channel_selected,
   output var rtc_pkg::rtc_analog_type analog_ctrl,
   output logic                        temp_to_converter
);
   logic [7:0]   reference_control;
   logic         reference_ready;
   logic         settled;
   logic         acq_done;
   logic [3:0]   aw_addr;
   logic         aw_held;
   logic [31:0]  w_data;
   logic         w_strb0;
   logic         w_held;
   logic         chan_meta;
   logic         chan_sync;
   logic         write_fire;
   logic         control_write;
   logic         write_known;

   // Register word decode from the byte address, shared by all channels
   function automatic logic is_control_word(input logic [3:0] addr);
      return addr[3:2] == rtc_pkg::ADDR_REF_CONTROL[3:2];
   endfunction

   // Status word holds the acquisition-done flag only
   function automatic logic is_status_word(input logic [3:0] addr);
      return addr[3:2] == rtc_pkg::ADDR_TEMP_STATUS[3:2];
   endfunction

   // Control byte as read back, live ready flag in place of the stored bit
   function automatic logic [7:0] control_readback(input logic [7:0] ctrl, input logic ready);
      logic [7:0] value;
      value                         = ctrl & rtc_pkg::CONTROL_WMASK;
      value[rtc_pkg::BIT_REF_READY] = ready;
      return value;
   endfunction

   // Both halves of a write held; commit and answer on this edge
   assign write_fire    = aw_held && w_held;
   // Only a write with the low byte lane reaches the control register
   assign control_write = write_fire && is_control_word(aw_addr) && w_strb0;
   // Unmapped words answer with an error and change nothing
   assign write_known   = is_control_word(aw_addr) || is_status_word(aw_addr);

   // Reference settling
   // Timer restarts whenever the enable drops
   rtc_settle_timer #(.COUNT(SETTLE_CYCLES)) u_settle (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .run     (reference_control[rtc_pkg::BIT_REF_ENABLE]),
      .done    (settled)
   );

   // Temperature channel acquisition wait (status for software)
   rtc_settle_timer #(.COUNT(TEMP_ACQ_CYCLES)) u_acq (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .run     (chan_sync & reference_control[rtc_pkg::BIT_TEMP_ENABLE]),
      .done    (acq_done)
   );

   // Channel select synchroniser
   // Only the second stage is read by logic
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_meta <= 1'b0;
         chan_sync <= 1'b0;
      end else begin
         chan_meta <= temp_channel_selected;
         chan_sync <= chan_meta;
      end
   end

   // Ready flag
   // Standard variant ties the flag high
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reference_ready <= STANDARD_VARIANT;
      end else if (STANDARD_VARIANT) begin
         reference_ready <= 1'b1;
      end else begin
         reference_ready <= settled & reference_control[rtc_pkg::BIT_REF_ENABLE];
      end
   end

   // Write address and data capture, either order
   // Each half waits in its holding slot for the other
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
         w_held  <= 1'b0;
         w_data  <= 32'h0;
         w_strb0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_strb0 <= s_axi_wstrb[0];
         end else if (aw_held && w_held) begin
            w_held <= 1'b0;
         end
      end
   end

   // Ready strobes: accept when slot free and no response pending
   // Ready drops for the cycle after each handshake, so a held valid is never taken twice
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready)
                          && !(aw_held && w_held);
         s_axi_wready  <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready)
                          && !(aw_held && w_held);
      end
   end

   // Control register write
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reference_control <= rtc_pkg::CONTROL_RESET;
      end else if (control_write) begin
         reference_control <= w_data[7:0] & rtc_pkg::CONTROL_WMASK;
      end
   end

   // Write response
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rtc_pkg::AXI_OKAY;
      end else if (write_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= write_known ? rtc_pkg::AXI_OKAY : rtc_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   // Data captured at the address handshake, held until taken
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= rtc_pkg::AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rtc_pkg::AXI_OKAY;
            if (is_control_word(s_axi_araddr)) begin
               s_axi_rdata <= {24'h0, control_readback(reference_control, reference_ready)};
            end else if (is_status_word(s_axi_araddr)) begin
               s_axi_rdata <= {31'h0, acq_done};
            end else begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= rtc_pkg::AXI_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Analog control outputs
   // Registered copy of the control fields for the analog side
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         analog_ctrl       <= '0;
         temp_to_converter <= 1'b0;
      end else begin
         analog_ctrl.ref_enable      <= reference_control[rtc_pkg::BIT_REF_ENABLE];
         analog_ctrl.temp_enable     <= reference_control[rtc_pkg::BIT_TEMP_ENABLE];
         analog_ctrl.temp_high_range <= reference_control[rtc_pkg::BIT_TEMP_RANGE];
         analog_ctrl.cmp_gain        <= rtc_pkg::rtc_gain_type'(reference_control[rtc_pkg::LSB_CMP_GAIN +: 2]);
         analog_ctrl.cnv_gain        <= rtc_pkg::rtc_gain_type'(reference_control[rtc_pkg::LSB_CNV_GAIN +: 2]);
         temp_to_converter <= reference_control[rtc_pkg::BIT_TEMP_ENABLE] & chan_sync;
      end
   end
endmodule // rtc_top
`default_nettype wire

// [rtl/rtc_pkg.sv]
package rtc_pkg;
   // Register map
   localparam logic [3:0] ADDR_REF_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_TEMP_STATUS = 4'h4;
   // Control field positions
   localparam int BIT_REF_ENABLE   = 7;
   localparam int BIT_REF_READY    = 6;
   localparam int BIT_TEMP_ENABLE  = 5;
   localparam int BIT_TEMP_RANGE   = 4;
   localparam int LSB_CMP_GAIN     = 2;
   localparam int LSB_CNV_GAIN     = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WMASK = 8'hbf;
   // Gain codes
   typedef enum logic [1:0] {
      RTC_GAIN_OFF = 2'h0,
      RTC_GAIN_X1  = 2'h1,
      RTC_GAIN_X2  = 2'h2,
      RTC_GAIN_X4  = 2'h3
   } rtc_gain_type;
   // Settling and channel-acquisition timing
   localparam int SYS_CLK_MHZ       = 100;
   localparam int SETTLE_TIME_US    = 25;
   localparam int SETTLE_CYCLES     = SETTLE_TIME_US * SYS_CLK_MHZ;
   localparam int TEMP_ACQ_TIME_US  = 200;
   localparam int TEMP_ACQ_CYCLES   = TEMP_ACQ_TIME_US * SYS_CLK_MHZ;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // Analog control bundle
   typedef struct packed {
      logic         ref_enable;
      logic         temp_enable;
      logic         temp_high_range;
      rtc_gain_type cmp_gain;
      rtc_gain_type cnv_gain;
   } rtc_analog_type;
endpackage

// [rtl/rtc_settle_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_settle_timer #(
   parameter int COUNT = 2500
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic run,
   output logic      done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] count;

   // Counts while run is high, restarts when it drops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         done  <= 1'b0;
      end else if (!run) begin
         count <= '0;
         done  <= 1'b0;
      end else if (count == W'(COUNT - 1)) begin
         done <= 1'b1;
      end else begin
         count <= count + W'(1);
      end
   end
endmodule // rtc_settle_timer
`default_nettype wire

// [dv/rtc_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_checker (
   input wire logic                    sys_clk,
   input wire logic                    rst_b,
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic                    s_axi_rvalid,
   input wire logic [31:0]             s_axi_rdata,
   input wire rtc_pkg::rtc_analog_type analog_ctrl,
   input wire logic                    temp_to_converter
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Bus handshakes
   sequence write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_reset_clears: assert property (disable iff (1'b0) !rst_b |=> analog_ctrl == '0 && !temp_to_converter)
      else $error("outputs not cleared in reset");
   chk_ctrl_on_write: assert property ($changed(analog_ctrl) |-> $past(s_axi_bvalid))
      else $error("control moved without a write");
   chk_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
      else $error("read data late");
   chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_temp_route: assert property (!analog_ctrl.temp_enable && !$past(analog_ctrl.temp_enable) |-> !temp_to_converter)
      else $error("sensor routed while off");
endmodule // rtc_checker
bind rtc_top rtc_checker u_chk (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .analog_ctrl, .temp_to_converter);
`default_nettype wire

// [dv/rtc_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_top_tb_top;
   logic        sys_clk = 1'b0, rst_b = 1'b0, temp_channel_selected = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, temp_to_converter;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   rtc_pkg::rtc_analog_type analog_ctrl;
   int          failures = 0, cmp_count = 0, cycles = 0;
   rtc_top #(.SETTLE_CYCLES(8), .TEMP_ACQ_CYCLES(8)) dut (.*);
   // Standard variant copy on the same inputs, only its read data observed
   logic [31:0] std_rdata, std_rd;
   rtc_top #(.STANDARD_VARIANT(1'b1), .SETTLE_CYCLES(8), .TEMP_ACQ_CYCLES(8)) dut_std (.*, .s_axi_awready(),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(std_rdata),
      .s_axi_rresp(), .s_axi_rvalid(), .analog_ctrl(), .temp_to_converter());
   initial forever #5 sys_clk = ~sys_clk;
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Bus write, each channel released once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      std_rd = std_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Every gain code on both paths, ready bit write ignored
   task automatic t_fields();
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {1'b1, 1'b1, i[0], i[1], i[1:0], ~i[1:0]};
         wr(4'h0, 32'h0, 4'hf);
         wr(4'h0, {24'h0, v}, 4'hf);
         rd(4'h0);
         check("control", rd_data, {24'h0, v & 8'hbf});
         check("analog", {25'h0, analog_ctrl}, {25'h0, v[7], v[5:0]});
      end
   endtask
   task automatic t_settle();
      wr(4'h0, 32'h0, 4'hf);
      wr(4'h0, 32'h80, 4'hf);
      rd(4'h0);
      check("early ready", rd_data, 32'h80);
      check("std ready on", std_rd, 32'hc0);
      repeat (12) @(posedge sys_clk);
      rd(4'h0);
      check("ready", rd_data, 32'hc0);
      wr(4'h0, 32'h0, 4'hf);
      rd(4'h0);
      check("ready off", rd_data, 32'h0);
      check("std ready off", std_rd, 32'h40);
   endtask
   task automatic t_refused();
      wr(4'h8, 32'hff, 4'hf);
      check("bad wr", resp, rtc_pkg::AXI_SLVERR);
      rd(4'h8);
      check("bad rd", resp, rtc_pkg::AXI_SLVERR);
      wr(4'h0, 32'hff, 4'h0);
      rd(4'h0);
      check("no strobe", rd_data, 32'h0);
   endtask
   task automatic t_temp();
      wr(4'h0, 32'h20, 4'hf);
      temp_channel_selected <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("route", {31'h0, temp_to_converter}, 32'h1);
      repeat (12) @(posedge sys_clk);
      rd(4'h4);
      check("acquired", rd_data, 32'h1);
      temp_channel_selected <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("unroute", {31'h0, temp_to_converter}, 32'h0);
   endtask
   // Clear at start and on a reset mid-run
   task automatic t_reset();
      rd(4'h0);
      check("reset value", rd_data, 32'h0);
      check("std reset ready", std_rd, 32'h40);
      wr(4'h0, 32'hbf, 4'hf);
      check("wr resp", resp, rtc_pkg::AXI_OKAY);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("analog reset", {25'h0, analog_ctrl}, 32'h0);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(4'h0);
      check("reg reset", rd_data, 32'h0);
      check("rd resp", resp, rtc_pkg::AXI_OKAY);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_fields();
      t_settle();
      t_refused();
      t_temp();
      conclude();
   end
endmodule // rtc_top_tb_top
`default_nettype wire
